// ==== sbf_baud_status.sv ====
// Baud divider chain, minimal transmitter and receiver, status flags and
// interrupt request, behind an APB slave. Assumes a single clk_sys domain;
// rx_pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
`include "sbf_consts.svh"

module sbf_baud_status
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_pin,
    output logic             tx_serial,
    output logic             tx_drive,
    output logic             irq
);

    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [2:0]  prescale_select_q;
    logic [2:0]  rate_select_q;
    logic        tx_empty_irq_en_q;
    logic        tx_complete_irq_en_q;
    logic        rx_irq_en_q;
    logic        idle_irq_en_q;
    logic        tx_enable_q;
    logic [6:0]  flags_q;
    logic [6:0]  arm_q;
    logic [6:0]  flag_set;
    logic [6:0]  flag_clr;
    logic [7:0]  rx_data_holding_q;
    logic        irq_q;
    logic        access;
    logic        setup;
    logic        mapped;
    logic        wr_data;
    logic        rd_data;
    logic        rd_status;
    logic [7:0]  pre_div;
    logic [7:0]  rate_div;
    logic        pre_tick;
    logic        rt_tick;
    logic        bit_tick;
    logic [7:0]  read_mux;

    assign setup     = psel && !penable;
    assign access    = psel && penable && pready_q;
    assign mapped    = (paddr == `SBF_ADDR_BAUD) || (paddr == `SBF_ADDR_CTRL)
                    || (paddr == `SBF_ADDR_STATUS) || (paddr == `SBF_ADDR_DATA);
    assign wr_data   = access && pwrite && (paddr == `SBF_ADDR_DATA);
    assign rd_data   = access && !pwrite && (paddr == `SBF_ADDR_DATA);
    assign rd_status = access && !pwrite && (paddr == `SBF_ADDR_STATUS);

    always_comb
    begin
        read_mux = 8'h00;
        unique case (paddr)
            `SBF_ADDR_BAUD:   read_mux = {1'b0, prescale_select_q,
                                          1'b0, rate_select_q};
            `SBF_ADDR_CTRL:   read_mux = {tx_empty_irq_en_q,
                                          tx_complete_irq_en_q, rx_irq_en_q,
                                          idle_irq_en_q, tx_enable_q, 3'h0};
            `SBF_ADDR_STATUS: read_mux = {flags_q, 1'b0};
            `SBF_ADDR_DATA:   read_mux = rx_data_holding_q;
            default:          read_mux = 8'h00;
        endcase
    end

    // No wait state: data and answer are registered in the setup cycle
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            if (setup)
                prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_mux};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prescale_select_q    <= `SBF_PRE_RESET;
            tx_empty_irq_en_q    <= 1'b0;
            tx_complete_irq_en_q <= 1'b0;
            rx_irq_en_q          <= 1'b0;
            idle_irq_en_q        <= 1'b0;
            tx_enable_q          <= 1'b0;
        end
        else if (access && pwrite)
        begin
            if (paddr == `SBF_ADDR_BAUD)
                prescale_select_q <= pwdata[`SBF_PRE_LSB +: 3];
            if (paddr == `SBF_ADDR_CTRL)
            begin
                tx_empty_irq_en_q    <= pwdata[`SBF_CTRL_TIE];
                tx_complete_irq_en_q <= pwdata[`SBF_CTRL_TX_COMPLETE_IRQ_EN];
                rx_irq_en_q          <= pwdata[`SBF_CTRL_RIE];
                idle_irq_en_q        <= pwdata[`SBF_CTRL_IDLE_IRQ_EN];
                tx_enable_q          <= pwdata[`SBF_CTRL_TE];
            end
        end
    end

    // Deliberately outside reset: keeps its value across a reset
    always_ff @(posedge clk_sys)
    begin
        if (access && pwrite && (paddr == `SBF_ADDR_BAUD))
            rate_select_q <= pwdata[`SBF_RATE_LSB +: 3];
    end

    always_comb
    begin
        unique case (prescale_select_q)
            3'h0:    pre_div = `SBF_DIV_P0;
            3'h1:    pre_div = `SBF_DIV_P1;
            3'h2:    pre_div = `SBF_DIV_P2;
            3'h3:    pre_div = `SBF_DIV_P3;
            3'h4:    pre_div = `SBF_DIV_P4;
            default: pre_div = `SBF_DIV_P4;
        endcase
    end

    assign rate_div = 8'h01 << rate_select_q;

    sbf_divider u_pre_div (.clk_sys(clk_sys), .reset_n(reset_n),
        .step(1'b1), .divisor(pre_div), .tick(pre_tick));
    sbf_divider u_rate_div (.clk_sys(clk_sys), .reset_n(reset_n),
        .step(pre_tick), .divisor(rate_div), .tick(rt_tick));
    sbf_divider u_bit_div (.clk_sys(clk_sys), .reset_n(reset_n),
        .step(rt_tick), .divisor(`SBF_RT_PER_BIT), .tick(bit_tick));

    // Transmitter: holding register plus shifter, stepped by the bit clock
    sbf_pkg::sbf_tx_state_t tx_state_q;
    logic [9:0] tx_shift_q;
    logic [3:0] tx_bit_q;
    logic [7:0] tx_data_holding_q;
    logic       tx_hold_full_q;
    logic       tx_en_prev_q;
    logic       tx_empty_flag_set_q;
    logic       tc_set_q;
    logic       tx_serial_q;
    logic       tx_drive_q;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_state_q        <= sbf_pkg::TX_OFF;
            tx_shift_q        <= 10'h3FF;
            tx_bit_q          <= 4'h0;
            tx_data_holding_q <= 8'h00;
            tx_hold_full_q    <= 1'b0;
            tx_en_prev_q      <= 1'b0;
            tx_empty_flag_set_q        <= 1'b0;
            tc_set_q          <= 1'b0;
            tx_serial_q       <= 1'b1;
            tx_drive_q        <= 1'b0;
        end
        else
        begin
            tx_en_prev_q <= tx_enable_q;
            tx_empty_flag_set_q   <= tx_enable_q && !tx_en_prev_q;
            tc_set_q     <= tx_enable_q && !tx_en_prev_q;
            if (bit_tick)
            begin
                unique case (tx_state_q)
                    sbf_pkg::TX_OFF:
                        if (tx_enable_q)
                        begin
                            tx_state_q <= sbf_pkg::TX_PREAMBLE;
                            tx_drive_q <= 1'b1;
                            tx_shift_q <= 10'h3FF;
                            tx_bit_q   <= 4'h0;
                        end
                    sbf_pkg::TX_IDLE:
                        if (!tx_enable_q)
                        begin
                            tx_state_q <= sbf_pkg::TX_OFF;
                            tx_drive_q <= 1'b0;
                        end
                        else if (tx_hold_full_q)
                        begin
                            tx_state_q     <= sbf_pkg::TX_SHIFT;
                            tx_shift_q     <= {1'b1, tx_data_holding_q, 1'b0};
                            tx_bit_q       <= 4'h0;
                            tx_hold_full_q <= 1'b0;
                            tx_empty_flag_set_q     <= 1'b1;
                        end
                    sbf_pkg::TX_PREAMBLE, sbf_pkg::TX_SHIFT:
                        if (tx_bit_q != `SBF_FRAME_BITS)
                        begin
                            tx_serial_q <= tx_shift_q[0];
                            tx_shift_q  <= {1'b1, tx_shift_q[9:1]};
                            tx_bit_q    <= tx_bit_q + 4'h1;
                        end
                        else if (!tx_enable_q)
                        begin
                            // Frame done after a stop request: drop the queue
                            tx_state_q     <= sbf_pkg::TX_OFF;
                            tx_drive_q     <= 1'b0;
                            tx_hold_full_q <= 1'b0;
                            tx_empty_flag_set_q     <= 1'b1;
                            tc_set_q       <= 1'b1;
                        end
                        else
                        begin
                            tx_state_q <= sbf_pkg::TX_IDLE;
                            tc_set_q   <= !tx_hold_full_q;
                        end
                endcase
            end
            if (wr_data && tx_enable_q)
            begin
                tx_data_holding_q <= pwdata[7:0];
                tx_hold_full_q    <= 1'b1;
            end
        end
    end

    // Receiver: 16x sampling with a three-sample vote in mid bit
    sbf_pkg::sbf_rx_state_t rx_state_q;
    logic       rx_meta_q;
    logic       rx_line_q;
    logic [3:0] rx_rt_q;
    logic [3:0] rx_bit_q;
    logic [2:0] rx_vote_q;
    logic [7:0] rx_shift_q;
    logic       rx_noise_q;
    logic       rx_done_q;
    logic       rx_char_nf_q;
    logic       rx_char_fe_q;
    logic [7:0] rx_idle_cnt_q;
    logic       line_idle_q;
    logic       idle_set_q;
    logic       vote_maj;
    logic       vote_noisy;

    assign vote_maj   = (rx_vote_q[0] & rx_vote_q[1]) |
                        (rx_vote_q[0] & rx_vote_q[2]) |
                        (rx_vote_q[1] & rx_vote_q[2]);
    assign vote_noisy = !((&rx_vote_q) || !(|rx_vote_q));

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_meta_q <= 1'b1;
            rx_line_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= rx_pin;
            rx_line_q <= rx_meta_q;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_state_q   <= sbf_pkg::RX_WAIT;
            rx_rt_q      <= 4'h0;
            rx_bit_q     <= 4'h0;
            rx_vote_q    <= 3'h0;
            rx_shift_q   <= 8'h00;
            rx_noise_q   <= 1'b0;
            rx_done_q    <= 1'b0;
            rx_char_nf_q <= 1'b0;
            rx_char_fe_q <= 1'b0;
        end
        else
        begin
            rx_done_q <= 1'b0;
            if (rt_tick)
            begin
                unique case (rx_state_q)
                    sbf_pkg::RX_WAIT:
                        if (!rx_line_q)
                        begin
                            rx_state_q <= sbf_pkg::RX_BITS;
                            rx_rt_q    <= 4'h1;
                            rx_bit_q   <= 4'h0;
                            rx_noise_q <= 1'b0;
                        end
                    sbf_pkg::RX_BITS:
                    begin
                        rx_rt_q <= rx_rt_q + 4'h1;
                        if (rx_rt_q == `SBF_SAMPLE_A)
                            rx_vote_q[0] <= rx_line_q;
                        if (rx_rt_q == `SBF_SAMPLE_B)
                            rx_vote_q[1] <= rx_line_q;
                        if (rx_rt_q == `SBF_SAMPLE_C)
                            rx_vote_q[2] <= rx_line_q;
                        if (rx_rt_q == `SBF_RT_LAST)
                        begin
                            rx_bit_q   <= rx_bit_q + 4'h1;
                            rx_noise_q <= rx_noise_q || vote_noisy;
                            if (rx_bit_q == 4'h0 && vote_maj)
                                rx_state_q <= sbf_pkg::RX_WAIT;
                            else if (rx_bit_q == `SBF_STOP_BIT)
                            begin
                                rx_state_q   <= sbf_pkg::RX_WAIT;
                                rx_done_q    <= 1'b1;
                                rx_char_nf_q <= rx_noise_q || vote_noisy;
                                rx_char_fe_q <= !vote_maj;
                            end
                            else if (rx_bit_q != 4'h0)
                                rx_shift_q <= {vote_maj, rx_shift_q[7:1]};
                        end
                    end
                endcase
            end
        end
    end

    // Idle after one character time of ones; flag only on the rising edge
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_idle_cnt_q <= 8'h00;
            line_idle_q   <= 1'b1;
            idle_set_q    <= 1'b0;
        end
        else
        begin
            idle_set_q <= 1'b0;
            if (rt_tick)
            begin
                if (!rx_line_q)
                begin
                    rx_idle_cnt_q <= 8'h00;
                    line_idle_q   <= 1'b0;
                end
                else if (!line_idle_q)
                begin
                    if (rx_idle_cnt_q == `SBF_IDLE_RT_LAST)
                    begin
                        line_idle_q <= 1'b1;
                        idle_set_q  <= 1'b1;
                    end
                    else
                        rx_idle_cnt_q <= rx_idle_cnt_q + 8'h01;
                end
            end
        end
    end

    // Flags: set wins over the clearing sequence of the same cycle
    logic rx_load;

    assign flag_clr = arm_q & {wr_data, wr_data, {5{rd_data}}};
    assign rx_load  = rx_done_q &&
                      (!flags_q[`SBF_F_RX_FULL_FLAG] || flag_clr[`SBF_F_RX_FULL_FLAG]);
    assign flag_set = {tx_empty_flag_set_q, tc_set_q, rx_load, idle_set_q,
                       rx_done_q && !rx_load,
                       rx_load && rx_char_nf_q, rx_load && rx_char_fe_q};

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags_q <= 7'h00;
            arm_q   <= 7'h00;
        end
        else
        begin
            flags_q <= flag_set |
                       (flags_q & ~flag_clr & ~{5'h00, rx_load, rx_load});
            if (rd_status)
                arm_q <= prdata_q[7:1];
            else
                arm_q <= arm_q & ~flag_clr;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rx_data_holding_q <= 8'h00;
        else if (rx_load)
            rx_data_holding_q <= rx_shift_q;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            irq_q <= 1'b0;
        else
            irq_q <= (tx_empty_irq_en_q && flags_q[`SBF_F_TX_EMPTY_FLAG]) ||
                     (tx_complete_irq_en_q && flags_q[`SBF_F_TC]) ||
                     (rx_irq_en_q && (flags_q[`SBF_F_RX_FULL_FLAG] ||
                                      flags_q[`SBF_F_OR])) ||
                     (idle_irq_en_q && flags_q[`SBF_F_IDLE]);
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign tx_serial = tx_serial_q;
    assign tx_drive  = tx_drive_q;
    assign irq       = irq_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_last_frame_stop;
        bit_tick && tx_state_q == sbf_pkg::TX_SHIFT &&
        tx_bit_q == `SBF_FRAME_BITS && !tx_enable_q;
    endsequence

    chk_prescale_thirteen: assert property
        (prescale_select_q == 3'h3 |-> pre_div == 8'h0D)
        else $error("prescale code 011 not divide by 13");
    chk_rt_after_pre: assert property
        (rt_tick |-> $past(pre_tick))
        else $error("timing tick without prescaler tick");
    chk_bit_after_rt: assert property
        (bit_tick |-> $past(rt_tick))
        else $error("bit tick without timing tick");
    chk_enable_sets_tx: assert property
        ($rose(tx_enable_q) |-> ##2 flags_q[`SBF_F_TX_EMPTY_FLAG] && flags_q[`SBF_F_TC])
        else $error("enable did not set transmit flags");
    chk_rx_full_sticky: assert property
        (flags_q[`SBF_F_RX_FULL_FLAG] && !flag_clr[`SBF_F_RX_FULL_FLAG] |=>
         flags_q[`SBF_F_RX_FULL_FLAG])
        else $error("receive-full dropped without clear");
    chk_stop_holds_pin: assert property
        (tx_state_q == sbf_pkg::TX_SHIFT && !tx_enable_q |-> tx_drive_q)
        else $error("pin released mid frame");
    chk_frame_end_off: assert property
        (s_last_frame_stop |=> !tx_drive_q && !tx_hold_full_q
         ##1 flags_q[`SBF_F_TX_EMPTY_FLAG] && flags_q[`SBF_F_TC])
        else $error("disabled frame end wrong");
    chk_overrun_keeps: assert property
        (rx_done_q && flags_q[`SBF_F_RX_FULL_FLAG] && !flag_clr[`SBF_F_RX_FULL_FLAG] |=>
         $stable(rx_data_holding_q) && flags_q[`SBF_F_OR])
        else $error("overrun lost held character");
    chk_idle_edge_only: assert property
        ($rose(flags_q[`SBF_F_IDLE]) |-> $past(idle_set_q))
        else $error("idle flag set without busy to idle");
    chk_irq_or: assert property
        (rx_irq_en_q && flags_q[`SBF_F_OR] |=> irq_q)
        else $error("overrun did not request interrupt");

endmodule // sbf_baud_status

// ==== sbf_consts.svh ====
// Register offsets, field positions, reset values and timing counts for the
// serial baud divider and status flag block. Included by sbf_baud_status and the bench.
`ifndef SBF_CONSTS_SVH
`define SBF_CONSTS_SVH

`define SBF_ADDR_BAUD     8'h00
`define SBF_ADDR_CTRL     8'h04
`define SBF_ADDR_STATUS   8'h08
`define SBF_ADDR_DATA     8'h0C

`define SBF_RATE_LSB      0
`define SBF_PRE_LSB       4
`define SBF_PRE_RESET     3'h0

`define SBF_CTRL_TIE      7
`define SBF_CTRL_TX_COMPLETE_IRQ_EN     6
`define SBF_CTRL_RIE      5
`define SBF_CTRL_IDLE_IRQ_EN     4
`define SBF_CTRL_TE       3

`define SBF_F_TX_EMPTY_FLAG        6
`define SBF_F_TC          5
`define SBF_F_RX_FULL_FLAG        4
`define SBF_F_IDLE        3
`define SBF_F_OR          2
`define SBF_F_NF          1
`define SBF_F_FE          0

`define SBF_DIV_P0        8'h01
`define SBF_DIV_P1        8'h03
`define SBF_DIV_P2        8'h04
`define SBF_DIV_P3        8'h0D
`define SBF_DIV_P4        8'h27

`define SBF_RT_PER_BIT    8'h10
`define SBF_RT_LAST       4'hF
`define SBF_FRAME_BITS    4'hA
`define SBF_STOP_BIT      4'h9
`define SBF_IDLE_RT_LAST  8'h9F
`define SBF_SAMPLE_A      4'h7
`define SBF_SAMPLE_B      4'h8
`define SBF_SAMPLE_C      4'h9

`endif

// ==== sbf_pkg.sv ====
// State types of the serial baud divider and status flag block.
// Used by the main module through scoped names only.
package sbf_pkg;

    typedef enum logic [1:0] {
        TX_OFF      = 2'b00,
        TX_IDLE     = 2'b11,
        TX_SHIFT    = 2'b10,
        TX_PREAMBLE = 2'b01
    } sbf_tx_state_t;

    typedef enum logic {
        RX_WAIT = 1'b0,
        RX_BITS = 1'b1
    } sbf_rx_state_t;

endpackage

// ==== sbf_divider.sv ====
// Variable-modulus tick divider: one registered tick per divisor steps.
// Assumes the divisor is at least one and steps come from clk_sys logic.
`timescale 1ns/10ps

module sbf_divider
(
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       step,
    input  wire logic [7:0] divisor,
    output logic            tick
);

    logic [7:0] count_q;
    logic [7:0] limit;
    logic       wrap;

    assign limit = divisor - 8'h01;
    // Compare with >= so a smaller divisor written mid-count still wraps
    assign wrap  = (count_q >= limit);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= 8'h00;
            tick    <= 1'b0;
        end
        else
        begin
            tick <= step && wrap;
            if (step)
                count_q <= wrap ? 8'h00 : count_q + 8'h01;
        end
    end

endmodule // sbf_divider

// ==== sbf_remote_peer.sv ====
// Remote serial peer: sends framed characters on the receive line.
// Assumes the bench calls send right after a rising clock edge.
`timescale 1ns/10ps

module sbf_remote_peer
(
    input  wire logic clk_sys,
    output logic      line
);
    initial line = 1'b1;

    // Start bit, eight data bits LSB first, the given stop level, then one
    // bit time of idle so the receiver has settled before the caller reads
    task automatic send(input logic [7:0] b, input int cyc, input logic stp);
        for (int i = 0; i < 10; i++)
        begin
            line <= (i == 0) ? 1'b0 : (i == 9) ? stp : b[i - 1];
            repeat (cyc) @(posedge clk_sys);
        end
        line <= 1'b1;
        repeat (cyc) @(posedge clk_sys);
    endtask
endmodule // sbf_remote_peer

// ==== tb_top.sv ====
// Bench for the baud divider and status flags, driven over APB.
// Assumes the peer model and the design files are compiled first.
`timescale 1ns/10ps
`include "sbf_consts.svh"

module tb_top;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, rx_pin, tx_serial, tx_drive, irq, err;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [7:0]  baud_v [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h03};
    int          bit_v [6] = '{16, 48, 64, 208, 624, 128};

    always #10 clk_sys = ~clk_sys;

    sbf_baud_status uut (.clk_sys(clk_sys), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pin(rx_pin), .tx_serial(tx_serial),
        .tx_drive(tx_drive), .irq(irq));
    sbf_remote_peer peer (.clk_sys(clk_sys), .line(rx_pin));

    task automatic close_out;
        $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, `SBF_ADDR_STATUS, 32'h0);
        chk(rd & mask, exp);
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            close_out;
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(1'b1, `SBF_ADDR_BAUD, 32'h13);
        // Rate divider is unknown until written; a second reset keeps it
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(1'b0, `SBF_ADDR_BAUD, 32'h0);
        chk(rd, 32'h03);
        apb(1'b1, `SBF_ADDR_BAUD, 32'h0);
        stat(32'hFF, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, `SBF_ADDR_BAUD, {24'h0, baud_v[i]});
            peer.send(8'h5A ^ 8'(i), bit_v[i], 1'b1);
            stat(32'h20, 32'h20);
            apb(1'b0, `SBF_ADDR_DATA, 32'h0);
            chk(rd, {24'h0, 8'h5A ^ 8'(i)});
        end
        apb(1'b1, `SBF_ADDR_CTRL, 32'h30);
        apb(1'b1, `SBF_ADDR_BAUD, 32'h0);
        peer.send(8'h11, 16, 1'b1);
        peer.send(8'h22, 16, 1'b1);
        stat(32'h28, 32'h28);
        apb(1'b0, `SBF_ADDR_DATA, 32'h0);
        chk(rd, 32'h11);
        stat(32'h28, 32'h00);
        peer.send(8'h33, 16, 1'b0);
        chk({31'h0, irq}, 32'h1);
        stat(32'h22, 32'h22);
        apb(1'b0, `SBF_ADDR_DATA, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        repeat (200) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        stat(32'h10, 32'h10);
        apb(1'b0, `SBF_ADDR_DATA, 32'h0);
        repeat (300) @(posedge clk_sys);
        stat(32'h10, 32'h00);
        apb(1'b1, `SBF_ADDR_CTRL, 32'h88);
        repeat (2) @(posedge clk_sys);
        stat(32'hC0, 32'hC0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `SBF_ADDR_CTRL, 32'h08);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `SBF_ADDR_CTRL, 32'h48);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        repeat (200) @(posedge clk_sys);
        apb(1'b1, `SBF_ADDR_DATA, 32'hA5);
        wait (tx_serial === 1'b0);
        apb(1'b1, `SBF_ADDR_CTRL, 32'h00);
        chk({31'h0, tx_drive}, 32'h1);
        stat(32'h40, 32'h00);
        repeat (200) @(posedge clk_sys);
        chk({30'h0, tx_drive, tx_serial}, 32'h1);
        stat(32'hC0, 32'hC0);
        close_out;
    end
endmodule // tb_top
